/* src/pifeb_pkg.sv */
// Register map, field positions and reset values of the flag/enable bank
package pifeb_pkg;
    // Byte offsets (word aligned) on the register bus
    localparam logic [7:0] OFS_FLAGS_B = 8'h00;
    localparam logic [7:0] OFS_FLAGS_C = 8'h04;
    localparam logic [7:0] OFS_ENABLES_A = 8'h08;
    localparam logic [7:0] OFS_ENABLES_B = 8'h0C;
    localparam logic [7:0] OFS_ENABLES_C = 8'h10;
    localparam logic [7:0] OFS_CONTROL = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    // Second flag / enable register fields
    localparam int BIT_OSC_FAIL = 7;
    localparam int BIT_COMPARATOR = 6;
    localparam int BIT_BUS_COLLISION = 3;
    localparam int BIT_LOW_VOLTAGE = 2;
    localparam int BIT_TIMER3 = 1;
    // Third flag / enable register fields
    localparam int BIT_DISPLAY = 6;
    localparam int BIT_SERIAL2_RX = 5;
    localparam int BIT_SERIAL2_TX = 4;
    localparam int BIT_CAPCOMP2 = 2;
    localparam int BIT_CAPCOMP1 = 1;
    // Control register fields
    localparam int BIT_PERIPH_GATE = 0;
    localparam int BIT_PRIO_ON = 1;
    localparam int BIT_DISPLAY_TYPE_B = 2;
    localparam int BIT_DISPLAY_NONSTATIC = 3;
    // Implemented-bit masks
    localparam logic [7:0] MASK_B = 8'hCE;
    localparam logic [7:0] MASK_C = 8'h76;
    localparam logic [7:0] MASK_C_SW = 8'h46;
    localparam logic [7:0] MASK_A = 8'h7B;
    localparam logic [3:0] MASK_CTRL = 4'hF;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_CTRL = 4'h0;
    // Capture/compare unit modes
    typedef enum logic [1:0] {
        PIFEB_CC_CAPTURE = 2'b00,
        PIFEB_CC_COMPARE = 2'b01,
        PIFEB_CC_PWM = 2'b11,
        PIFEB_CC_OFF = 2'b10
    } pifeb_cc_mode_t;
    // AHB transfer type
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage

/* src/pifeb_reg_if.sv */
`timescale 1ns/10ps
// Register access strobes from the bus slave to the register bank
interface pifeb_reg_if;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport slave (output wr_stb, output rd_stb, output addr,
        output wdata, input rdata);
    modport bank (input wr_stb, input rd_stb, input addr,
        input wdata, output rdata);
endinterface

/* src/pifeb_ahb_slave.sv */
`timescale 1ns/10ps
// AHB-Lite slave turning transfers into one-cycle register strobes
module pifeb_ahb_slave (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Register side
    pifeb_reg_if.slave rif
);
    logic wr_pend_r;
    logic [7:0] addr_r;
    logic take;

    assign take = hsel && hready && htrans == pifeb_pkg::HTRANS_NONSEQ;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase capture
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else if (clk_en) begin
            wr_pend_r <= take && hwrite;
            if (take) begin
                addr_r <= haddr[7:0];
            end
        end
    end

    // Reads are answered in the data phase from the registered read word
    always_ff @(posedge core_clk) begin
        if (reset) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en && take && !hwrite) begin
            hrdata <= {24'h00_0000, rif.rdata};
        end
    end

    assign rif.wr_stb = wr_pend_r && clk_en;
    assign rif.rd_stb = take && !hwrite && clk_en;
    assign rif.addr = rif.wr_stb ? addr_r : haddr[7:0];
    assign rif.wdata = hwdata[7:0];
endmodule // pifeb_ahb_slave

/* src/pifeb_cc_unit.sv */
`timescale 1ns/10ps
// Capture/compare event qualifier for one unit
module pifeb_cc_unit (
    // Mode and events
    input wire pifeb_pkg::pifeb_cc_mode_t mode,
    input wire logic capture_evt,
    input wire logic match_evt,
    // Result
    output logic flag_evt
);
    always_comb begin
        unique case (mode)
            pifeb_pkg::PIFEB_CC_CAPTURE: flag_evt = capture_evt;
            pifeb_pkg::PIFEB_CC_COMPARE: flag_evt = match_evt;
            pifeb_pkg::PIFEB_CC_PWM: flag_evt = 1'b0;
            pifeb_pkg::PIFEB_CC_OFF: flag_evt = 1'b0;
        endcase
    end
endmodule // pifeb_cc_unit

/* src/pifeb_top.sv */
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
// Peripheral interrupt flag and enable bank with AHB-Lite access
// What this block does
// (R1) Oscillator fail sets second flag bit 7
// (R2) Comparator change sets second flag bit 6
// (R3) Bus collision sets second flag bit 3
// (R4) Low voltage sets second flag bit 2
// (R5) Timer-3 overflow sets second flag bit 1
// (R6) Flags hold until software writes zero
// (R7) Unimplemented bits read as zero
// (R8) Display done sets third flag bit 6 in type-B non-static display mode
// (R9) Serial2 receive flag mirrors full buffer, read-only
// (R10) Serial2 transmit flag mirrors empty buffer, read-only
// (R11) Capture mode capture sets unit flag
// (R12) Compare mode match sets unit flag
// (R13) One enable bit per source, one enables
// (R14) Without priorities, peripheral gate also required
// (R15) Priority bits matter only with priorities on
// (R16) All bits reset to zero
// (R17) Flags set regardless of enables
// (R18) Request is OR of flag AND enable
// (R19) Software clears flag before enabling, after servicing
module pifeb_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Peripheral events, one-cycle pulses on core_clk, and capture/compare unit modes
    input wire logic osc_fail_evt,
    input wire logic comparator_evt,
    input wire logic bus_collision_evt,
    input wire logic low_voltage_evt,
    input wire logic timer3_overflow_evt,
    input wire logic display_frame_evt,
    input wire logic cc1_capture_evt,
    input wire logic cc1_match_evt,
    input wire logic cc2_capture_evt,
    input wire logic cc2_match_evt,
    input wire pifeb_pkg::pifeb_cc_mode_t cc1_mode,
    input wire pifeb_pkg::pifeb_cc_mode_t cc2_mode,
    // Second serial port buffer levels
    input wire logic serial2_rx_full,
    input wire logic serial2_tx_empty,
    // First flag register, kept outside
    input wire logic [7:0] periph_flags_a,
    // Requests to the core
    output logic periph_irq,
    output logic periph_irq_raw,
    output logic priority_levels_on,
    output logic peripheral_irq_gate
);
    pifeb_reg_if rif ();

    logic [7:0] periph_flags_b_r;
    logic [7:0] flags_c_sw_r;
    logic [7:0] periph_enables_a_r;
    logic [7:0] periph_enables_b_r;
    logic [7:0] periph_enables_c_r;
    logic [3:0] control_r;
    logic [7:0] periph_flags_c;
    logic [7:0] ev_b;
    logic [7:0] ev_c;
    logic cc1_evt;
    logic cc2_evt;
    logic display_evt;
    logic wr_b;
    logic wr_c;

    function automatic logic [7:0] upd_flags(input logic [7:0] cur,
        input logic wr, input logic [7:0] wd, input logic [7:0] ev,
        input logic [7:0] mask);
        logic [7:0] base;
        base = wr ? wd : cur;
        return (base | ev) & mask;
    endfunction

    pifeb_ahb_slave u_slave (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .rif(rif)
    );

    pifeb_cc_unit u_cc1 (
        .mode(cc1_mode),
        .capture_evt(cc1_capture_evt),
        .match_evt(cc1_match_evt),
        .flag_evt(cc1_evt) // R11 R12
    );

    pifeb_cc_unit u_cc2 (
        .mode(cc2_mode),
        .capture_evt(cc2_capture_evt),
        .match_evt(cc2_match_evt),
        .flag_evt(cc2_evt) // R11 R12
    );

    // Display flag only in type-B non-static operation
    assign display_evt = display_frame_evt
        && control_r[pifeb_pkg::BIT_DISPLAY_TYPE_B]
        && control_r[pifeb_pkg::BIT_DISPLAY_NONSTATIC]; // R8

    always_comb begin
        ev_b = 8'h00;
        ev_b[pifeb_pkg::BIT_OSC_FAIL] = osc_fail_evt; // R1
        ev_b[pifeb_pkg::BIT_COMPARATOR] = comparator_evt; // R2
        ev_b[pifeb_pkg::BIT_BUS_COLLISION] = bus_collision_evt; // R3
        ev_b[pifeb_pkg::BIT_LOW_VOLTAGE] = low_voltage_evt; // R4
        ev_b[pifeb_pkg::BIT_TIMER3] = timer3_overflow_evt; // R5
    end

    always_comb begin
        ev_c = 8'h00;
        ev_c[pifeb_pkg::BIT_DISPLAY] = display_evt; // R8
        ev_c[pifeb_pkg::BIT_CAPCOMP2] = cc2_evt; // R11
        ev_c[pifeb_pkg::BIT_CAPCOMP1] = cc1_evt; // R12
    end

    assign wr_b = rif.wr_stb && rif.addr == pifeb_pkg::OFS_FLAGS_B;
    assign wr_c = rif.wr_stb && rif.addr == pifeb_pkg::OFS_FLAGS_C;

    // Second flag register; an event in the clear cycle wins
    always_ff @(posedge core_clk) begin
        if (reset) begin
            periph_flags_b_r <= pifeb_pkg::RST_BYTE; // R16
        end else if (clk_en) begin
            periph_flags_b_r <= upd_flags(periph_flags_b_r, wr_b,
                rif.wdata, ev_b, pifeb_pkg::MASK_B); // R6 R17 R7
        end
    end

    // Software-cleared part of the third flag register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            flags_c_sw_r <= pifeb_pkg::RST_BYTE; // R16
        end else if (clk_en) begin
            flags_c_sw_r <= upd_flags(flags_c_sw_r, wr_c, rif.wdata,
                ev_c, pifeb_pkg::MASK_C_SW); // R6 R17
        end
    end

    // Serial-port flags follow the buffers; buffer logic clears them
    always_comb begin
        periph_flags_c = flags_c_sw_r;
        periph_flags_c[pifeb_pkg::BIT_SERIAL2_RX] = serial2_rx_full; // R9
        periph_flags_c[pifeb_pkg::BIT_SERIAL2_TX] = serial2_tx_empty; // R10
    end

    // Enable registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            periph_enables_a_r <= pifeb_pkg::RST_BYTE; // R16
            periph_enables_b_r <= pifeb_pkg::RST_BYTE;
            periph_enables_c_r <= pifeb_pkg::RST_BYTE;
        end else if (clk_en && rif.wr_stb) begin
            unique case (rif.addr)
                pifeb_pkg::OFS_ENABLES_A:
                    periph_enables_a_r <= rif.wdata & pifeb_pkg::MASK_A;
                pifeb_pkg::OFS_ENABLES_B:
                    periph_enables_b_r <= rif.wdata & pifeb_pkg::MASK_B; // R13
                pifeb_pkg::OFS_ENABLES_C:
                    periph_enables_c_r <= rif.wdata & pifeb_pkg::MASK_C; // R7
                default: ;
            endcase
        end
    end

    // Control: peripheral gate, priority mode, display mode
    always_ff @(posedge core_clk) begin
        if (reset) begin
            control_r <= pifeb_pkg::RST_CTRL; // R16
        end else if (clk_en && rif.wr_stb
                && rif.addr == pifeb_pkg::OFS_CONTROL) begin
            control_r <= rif.wdata[3:0] & pifeb_pkg::MASK_CTRL;
        end
    end

    assign priority_levels_on = control_r[pifeb_pkg::BIT_PRIO_ON]; // R15
    assign peripheral_irq_gate = control_r[pifeb_pkg::BIT_PERIPH_GATE];

    // Any enabled flag
    assign periph_irq_raw = |(periph_flags_a & periph_enables_a_r)
        | |(periph_flags_b_r & periph_enables_b_r)
        | |(periph_flags_c & periph_enables_c_r); // R18 R13

    // Gate is bypassed when priority levels are on
    assign periph_irq = periph_irq_raw
        && (priority_levels_on || peripheral_irq_gate); // R14

    // Read multiplexer
    always_comb begin
        unique case (rif.addr)
            pifeb_pkg::OFS_FLAGS_B: rif.rdata = periph_flags_b_r;
            pifeb_pkg::OFS_FLAGS_C:
                rif.rdata = periph_flags_c & pifeb_pkg::MASK_C; // R7
            pifeb_pkg::OFS_ENABLES_A: rif.rdata = periph_enables_a_r;
            pifeb_pkg::OFS_ENABLES_B: rif.rdata = periph_enables_b_r;
            pifeb_pkg::OFS_ENABLES_C: rif.rdata = periph_enables_c_r;
            pifeb_pkg::OFS_CONTROL: rif.rdata = {4'h0, control_r};
            pifeb_pkg::OFS_STATUS:
                rif.rdata = {6'h00, periph_irq, periph_irq_raw};
            default: rif.rdata = 8'h00;
        endcase
    end
endmodule // pifeb_top

/* dv/pifeb_asserts.sv */
// Port-level checker for the flag and enable bank
`timescale 1ns/10ps
module pifeb_asserts (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Requests
    input wire logic periph_irq,
    input wire logic periph_irq_raw,
    input wire logic priority_levels_on,
    input wire logic peripheral_irq_gate
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic taken;
    logic rd_taken;
    logic ctrl_wr;
    assign taken = hsel && hready && clk_en
        && htrans == pifeb_pkg::HTRANS_NONSEQ;
    assign rd_taken = taken && !hwrite;
    assign ctrl_wr = taken && hwrite && haddr[7:0] == pifeb_pkg::OFS_CONTROL;
    AST_READY_ALWAYS: assert property (hreadyout)
        else $error("hreadyout low");
    AST_OKAY_RESP: assert property (!hresp)
        else $error("hresp not okay");
    AST_UPPER_ZERO: assert property (hrdata[31:8] == 24'h000000)
        else $error("hrdata upper bits set");
    AST_GATED_REQ: assert property (periph_irq ==
        (periph_irq_raw && (priority_levels_on || peripheral_irq_gate)))
        else $error("gated request wrong");
    AST_RESET_QUIET: assert property ($past(reset) |->
        !priority_levels_on && !peripheral_irq_gate && !periph_irq_raw)
        else $error("outputs not clear after reset");
    AST_HRDATA_RESET: assert property ($past(reset) |-> hrdata == 32'h0)
        else $error("hrdata not clear after reset");
    AST_CTRL_BY_WRITE: assert property (!$past(reset) &&
        ($changed(priority_levels_on) || $changed(peripheral_irq_gate))
        |-> $past(ctrl_wr, 2))
        else $error("control bit moved without write");
    AST_CTRL_LANDS: assert property (ctrl_wr ##1 clk_en |=>
        peripheral_irq_gate == $past(hwdata[pifeb_pkg::BIT_PERIPH_GATE])
        && priority_levels_on == $past(hwdata[pifeb_pkg::BIT_PRIO_ON]))
        else $error("control write did not land");
    AST_HRDATA_HOLDS: assert property (!$past(reset) && $changed(hrdata)
        |-> $past(rd_taken))
        else $error("hrdata moved without read");
endmodule // pifeb_asserts
bind pifeb_top pifeb_asserts i_asserts (.core_clk, .reset, .clk_en, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hwdata, .hreadyout, .hresp, .hrdata,
    .periph_irq, .periph_irq_raw, .priority_levels_on, .peripheral_irq_gate);

/* dv/pifeb_event_src.sv */
// Peripheral event source model: one-cycle pulses on the core clock
`timescale 1ns/10ps
module pifeb_event_src (
    // Clock
    input wire logic core_clk,
    // Event pulses
    output logic [9:0] evt
);
    initial evt = 10'h000;
    task automatic pulse(input int idx);
        @(posedge core_clk);
        evt[idx] <= 1'h1;
        @(posedge core_clk);
        evt[idx] <= 1'h0;
    endtask
endmodule // pifeb_event_src

/* dv/testbench.sv */
// Self-checking bench for the flag and enable bank
`timescale 1ns/10ps
module testbench;
    logic core_clk, reset = 1'h1, clk_en = 1'h1, hsel = 1'h1, hwrite = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, periph_irq, periph_irq_raw;
    logic priority_levels_on, peripheral_irq_gate;
    logic serial2_rx_full = 1'h0, serial2_tx_empty = 1'h0;
    logic [7:0] periph_flags_a = 8'h00;
    logic [9:0] evt;
    pifeb_pkg::pifeb_cc_mode_t cc1_mode = pifeb_pkg::PIFEB_CC_OFF;
    pifeb_pkg::pifeb_cc_mode_t cc2_mode = pifeb_pkg::PIFEB_CC_OFF;
    int n_errors = 0, samples_checked = 0, cycles = 0;
    logic [7:0] ofs[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [7:0] msk[5] = '{8'hCE, 8'h46, 8'h7B, 8'hCE, 8'h76};
    int bitb[5] = '{7, 6, 3, 2, 1};
    logic [7:0] exp_cc;
    assign hready = hreadyout;
    pifeb_event_src i_src (.core_clk, .evt);
    pifeb_top i_dut (.core_clk, .reset, .clk_en, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hready, .hwdata, .hreadyout, .hresp, .hrdata,
        .osc_fail_evt(evt[0]), .comparator_evt(evt[1]),
        .bus_collision_evt(evt[2]), .low_voltage_evt(evt[3]),
        .timer3_overflow_evt(evt[4]), .display_frame_evt(evt[5]),
        .cc1_capture_evt(evt[6]), .cc1_match_evt(evt[7]),
        .cc2_capture_evt(evt[8]), .cc2_match_evt(evt[9]), .cc1_mode,
        .cc2_mode, .serial2_rx_full, .serial2_tx_empty, .periph_flags_a,
        .periph_irq, .periph_irq_raw, .priority_levels_on,
        .peripheral_irq_gate);
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            $display("mismatch t=%0t timeout", $time);
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch t=%0t got %h want %h", $time, g, e);
        end
    endtask
    // Single AHB transfer: address phase, then data phase
    task automatic bus(input logic [7:0] a, input logic wr,
        input logic [7:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= pifeb_pkg::HTRANS_NONSEQ;
        do @(posedge core_clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        do @(posedge core_clk); while (hready !== 1'h1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(a, 1'h1, d, r);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] r;
        bus(a, 1'h0, 8'h00, r);
        chk(r, {24'h000000, e});
    endtask
    task automatic irq_chk(input logic raw, input logic gated);
        #1;
        chk({30'h0, periph_irq_raw, periph_irq}, {30'h0, raw, gated});
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'h0;
        for (int i = 0; i < 8; i++) rd_chk(8'(i * 4), 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 5; i++) begin
            wr(ofs[i], 8'hFF);
            rd_chk(ofs[i], msk[i]);
            wr(ofs[i], 8'h00);
            rd_chk(ofs[i], 8'h00);
        end
        wr(8'h1C, 8'hFF);
        rd_chk(8'h1C, 8'h00);
        wr(pifeb_pkg::OFS_STATUS, 8'hFF);
        rd_chk(pifeb_pkg::OFS_STATUS, 8'h00);
        $display("test register access done");
        for (int i = 0; i < 5; i++) begin
            i_src.pulse(i);
            repeat (3) @(posedge core_clk);
            rd_chk(pifeb_pkg::OFS_FLAGS_B, 8'(1 << bitb[i]));
            wr(pifeb_pkg::OFS_FLAGS_B, 8'h00);
        end
        clk_en <= 1'h0;
        i_src.pulse(0);
        clk_en <= 1'h1;
        rd_chk(pifeb_pkg::OFS_FLAGS_B, 8'h00);
        $display("test second flags done");
        i_src.pulse(5);
        rd_chk(pifeb_pkg::OFS_FLAGS_C, 8'h00);
        wr(pifeb_pkg::OFS_CONTROL, 8'h0C);
        i_src.pulse(5);
        rd_chk(pifeb_pkg::OFS_FLAGS_C, 8'h40);
        wr(pifeb_pkg::OFS_CONTROL, 8'h00);
        wr(pifeb_pkg::OFS_FLAGS_C, 8'h00);
        for (int m = 0; m < 4; m++) begin
            cc1_mode <= pifeb_pkg::pifeb_cc_mode_t'(m);
            cc2_mode <= pifeb_pkg::pifeb_cc_mode_t'(m);
            for (int e = 6; e < 10; e++) begin
                i_src.pulse(e);
                exp_cc = (m < 2 && m == e % 2) ? 8'(1 << (e < 8
                    ? pifeb_pkg::BIT_CAPCOMP1 : pifeb_pkg::BIT_CAPCOMP2))
                    : 8'h00;
                rd_chk(pifeb_pkg::OFS_FLAGS_C, exp_cc);
                wr(pifeb_pkg::OFS_FLAGS_C, 8'h00);
            end
        end
        serial2_rx_full <= 1'h1;
        rd_chk(pifeb_pkg::OFS_FLAGS_C, 8'h20);
        serial2_rx_full <= 1'h0;
        serial2_tx_empty <= 1'h1;
        wr(pifeb_pkg::OFS_FLAGS_C, 8'h00);
        rd_chk(pifeb_pkg::OFS_FLAGS_C, 8'h10);
        serial2_tx_empty <= 1'h0;
        $display("test third flags done");
        wr(pifeb_pkg::OFS_FLAGS_B, 8'h00);
        wr(pifeb_pkg::OFS_ENABLES_B, 8'h02);
        irq_chk(1'h0, 1'h0);
        i_src.pulse(4);
        irq_chk(1'h1, 1'h0);
        wr(pifeb_pkg::OFS_CONTROL, 8'h01);
        irq_chk(1'h1, 1'h1);
        rd_chk(pifeb_pkg::OFS_STATUS, 8'h03);
        wr(pifeb_pkg::OFS_CONTROL, 8'h02);
        irq_chk(1'h1, 1'h1);
        wr(pifeb_pkg::OFS_ENABLES_B, 8'h00);
        irq_chk(1'h0, 1'h0);
        periph_flags_a <= 8'h40;
        wr(pifeb_pkg::OFS_ENABLES_A, 8'h40);
        irq_chk(1'h1, 1'h1);
        $display("test request gating done");
        reset <= 1'h1;
        repeat (2) @(posedge core_clk);
        reset <= 1'h0;
        rd_chk(pifeb_pkg::OFS_FLAGS_B, 8'h00);
        rd_chk(pifeb_pkg::OFS_CONTROL, 8'h00);
        rd_chk(pifeb_pkg::OFS_STATUS, 8'h00);
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule // testbench
